// file: core/tbou_core.sv
/*
 * Transfer and single-bit operation unit with an APB register file.
 * Assumes an APB master on ref_clk; a write to CTRL runs one operation.
 */
// Operation
// - Transfers act on byte or word size
// - Nibble move copies one half, keeps other
// - Nibble move uses register zero low byte
// - Other nibble operand is a register zero/one byte or the destination low byte
// - Address move writes effective address, not contents
// - Register set saved or restored per instruction
// - Extended area via abs20, pair, or dsp20
// - Store if nonzero writes when zero clear
// - Store if zero writes when zero set
// - Select store picks immediate by zero flag
// - Conditional store immediates are eight bits
// - Swap exchanges source and destination
// - Bit move on sign and overflow conditions
// - Signed compare bit moves use sign xor overflow
// - Bit and/or/xor into carry
// - Inverted bit and/or/xor into carry
// - Bit clear, set and invert
// - Bit test loads carry and inverted zero
// - Test then clear the bit
// - Test then set the bit
// - Bit move keeps flags unless carry direct
// - Bit count shifted three gives byte offset
`timescale 1ns/10ps
module tbou_core #(
    parameter int unsigned STK_DEPTH = 16,
    parameter int unsigned EXT_DEPTH = 16
) (
    input  wire logic        ref_clk, // Core clock
    input  wire logic        rst_n,   // Async reset
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB enable
    input  wire logic        pwrite,  // APB direction
    input  wire logic [7:0]  paddr,   // APB byte address
    input  wire logic [31:0] pwdata,  // APB write data
    output logic      [31:0] prdata,  // APB read data
    output logic             pready,  // APB ready
    output logic             pslverr, // APB error
    output tbou_pkg::tbou_flags_t flags_out // Flag state
);
    import tbou_pkg::*;

    localparam int unsigned SP_W = $clog2(STK_DEPTH);
    localparam int unsigned XA_W = $clog2(EXT_DEPTH);

    tbou_state_t  state_r;
    tbou_flags_t  flag_r;
    tbou_flags_t  flag_nxt;
    tbou_ctrl_t   ctrl_r;
    tbou_ctrl_t   cw;
    logic [15:0]  src_r;
    logic [15:0]  src_nxt;
    logic [15:0]  dst_r;
    logic [15:0]  dst_nxt;
    logic [15:0]  imm_r;
    logic [15:0]  bitcnt_r;
    logic [19:0]  ea_r;
    logic [19:0]  xadr_r;
    logic [19:0]  xadr;
    logic [7:0]   mask_r;
    logic [2:0]   idx_r;
    logic [SP_W-1:0] sp_r;
    logic [15:0]  gpr [8];
    logic [15:0]  stk [STK_DEPTH];
    logic [7:0]   xmem [EXT_DEPTH];
    logic [31:0]  rd_mux;
    logic         acc;
    logic         was_idle_r;
    logic         wr;
    logic         exec;
    logic         nib_op;
    logic         mapped;
    logic [2:0]   bsel;
    logic         sbit;
    logic         dbit;
    logic         cond_ok;
    logic [7:0]   n_src;
    logic [7:0]   n_dst;
    logic [7:0]   n_val;
    logic [2:0]   n_tgt;
    logic [3:0]   n_sn;
    logic [XA_W-1:0] xi;
    logic [XA_W-1:0] xi1;

    function automatic logic gpr_hit(input logic [7:0] a);
        gpr_hit = (a[7:5] == GPR_PAGE) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [7:0] pick_byte(input logic [2:0] sel, input logic [15:0] g0,
                                             input logic [15:0] g1, input logic [15:0] d);
        unique case (sel)
            3'h0:    pick_byte = g0[7:0];
            3'h1:    pick_byte = g0[15:8];
            3'h2:    pick_byte = g1[7:0];
            3'h3:    pick_byte = g1[15:8];
            default: pick_byte = d[7:0];
        endcase
    endfunction

    function automatic logic cond_eval(input logic [3:0] cd, input tbou_flags_t f);
        unique case (cd)
            4'h0:    cond_eval = f.c;
            4'h1:    cond_eval = !f.c;
            4'h2:    cond_eval = f.z;
            4'h3:    cond_eval = !f.z;
            4'h4:    cond_eval = f.c & f.z;
            4'h5:    cond_eval = !(f.c & f.z);
            4'h6:    cond_eval = !f.s;
            4'h7:    cond_eval = f.s;
            4'h8:    cond_eval = !(f.s ^ f.o);
            4'h9:    cond_eval = (f.s ^ f.o) | f.z;
            4'ha:    cond_eval = !((f.s ^ f.o) | f.z);
            4'hb:    cond_eval = f.s ^ f.o;
            4'hc:    cond_eval = f.o;
            4'hd:    cond_eval = !f.o;
            default: cond_eval = 1'b0;
        endcase
    endfunction

    // Any access stalls while a register set transfer walks the mask,
    // plus one cycle so registered read data reflects the finished walk
    assign pready    = (state_r == ST_IDLE) && was_idle_r;
    assign acc       = psel & penable & pready;
    assign wr        = acc & pwrite;
    assign exec      = wr & (paddr == OFS_CTRL);
    assign cw        = tbou_ctrl_t'(pwdata);
    assign pslverr   = acc & !mapped;
    assign flags_out = flag_r;

    assign nib_op  = (cw.op >= OP_NHH) && (cw.op <= OP_NLL);
    assign bsel    = bitcnt_r[2:0];
    assign sbit    = src_r[bsel];
    assign dbit    = dst_r[bsel];
    assign cond_ok = cond_eval(cw.cond, flag_r);

    // Register zero low byte is always one side of a nibble move
    always_comb begin
        n_dst = pick_byte(cw.nsel, gpr[0], gpr[1], dst_r);
        n_src = gpr[0][7:0];
        n_tgt = cw.nsel;
        if (cw.ndir) begin
            n_src = n_dst;
            n_dst = gpr[0][7:0];
            n_tgt = NB_GPR0L;
        end
        n_sn = (cw.op == OP_NHH || cw.op == OP_NHL) ? n_src[7:4] : n_src[3:0];
        if (cw.op == OP_NHH || cw.op == OP_NLH) begin
            n_val = {n_sn, n_dst[3:0]};
        end else begin
            n_val = {n_dst[7:4], n_sn};
        end
    end

    always_comb begin
        unique case (cw.xmode)
            XM_PAIR:  xadr = {gpr[IDX_AR1][3:0], gpr[IDX_AR0]};
            XM_DSP20: xadr = ea_r + {4'h0, gpr[IDX_AR0]};
            default:  xadr = ea_r;
        endcase
    end
    assign xi  = xadr[XA_W-1:0];
    assign xi1 = xi + XA_W'(1);

    // Single-cycle operation results
    always_comb begin
        dst_nxt  = dst_r;
        src_nxt  = src_r;
        flag_nxt = flag_r;
        unique case (cw.op)
            OP_MOV:   dst_nxt = cw.word ? src_r : {dst_r[15:8], src_r[7:0]};
            OP_MVADR: dst_nxt = ea_r[15:0];
            OP_XLD:   dst_nxt = cw.word ? {xmem[xi1], xmem[xi]} : {dst_r[15:8], xmem[xi]};
            OP_CSNZ:  dst_nxt[7:0] = flag_r.z ? dst_r[7:0] : imm_r[7:0];
            OP_CSZ:   dst_nxt[7:0] = flag_r.z ? imm_r[7:0] : dst_r[7:0];
            OP_CSSEL: dst_nxt[7:0] = flag_r.z ? imm_r[7:0] : imm_r[15:8];
            OP_SWAP: begin
                dst_nxt = cw.word ? src_r : {dst_r[15:8], src_r[7:0]};
                src_nxt = cw.word ? dst_r : {src_r[15:8], dst_r[7:0]};
            end
            OP_BMOV: begin
                if (cw.fdir) begin
                    flag_nxt.c = cond_ok;
                end else begin
                    dst_nxt[bsel] = cond_ok;
                end
            end
            OP_BAND:  flag_nxt.c = sbit & flag_r.c;
            OP_BORC:  flag_nxt.c = sbit | flag_r.c;
            OP_BXORC: flag_nxt.c = sbit ^ flag_r.c;
            OP_NBAND: flag_nxt.c = !sbit & flag_r.c;
            OP_NBOR:  flag_nxt.c = !sbit | flag_r.c;
            OP_NBXOR: flag_nxt.c = !sbit ^ flag_r.c;
            OP_BZERO: dst_nxt[bsel] = 1'b0;
            OP_BSETO: dst_nxt[bsel] = 1'b1;
            OP_BINV:  dst_nxt[bsel] = !dbit;
            OP_BTEST: begin
                flag_nxt.c = sbit;
                flag_nxt.z = !sbit;
            end
            OP_NBTST: begin
                flag_nxt.c = !sbit;
                flag_nxt.z = !sbit;
            end
            OP_TCLR, OP_TSET: begin
                flag_nxt.c    = dbit;
                flag_nxt.z    = !dbit;
                dst_nxt[bsel] = (cw.op == OP_TSET);
            end
            default: begin
                if (nib_op && n_tgt == NB_MEM) begin
                    dst_nxt[7:0] = n_val;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dst_r <= '0;
        end else if (exec) begin
            dst_r <= dst_nxt;
        end else if (wr && paddr == OFS_DST) begin
            dst_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_r <= '0;
        end else if (exec) begin
            src_r <= src_nxt;
        end else if (wr && paddr == OFS_SRC) begin
            src_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= tbou_flags_t'(RST_FLAGS);
        end else if (exec) begin
            flag_r <= flag_nxt;
        end else if (wr && paddr == OFS_FLAGS) begin
            flag_r <= tbou_flags_t'(pwdata[3:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r   <= '0;
            imm_r    <= '0;
            bitcnt_r <= '0;
            ea_r     <= '0;
            mask_r   <= '0;
        end else if (wr) begin
            if (paddr == OFS_CTRL) ctrl_r <= cw;
            if (paddr == OFS_IMM) imm_r <= pwdata[15:0];
            if (paddr == OFS_BITCNT) bitcnt_r <= pwdata[15:0];
            if (paddr == OFS_EA) ea_r <= pwdata[19:0];
            if (paddr == OFS_MASK) mask_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xadr_r <= '0;
        end else if (exec && (cw.op == OP_XLD || cw.op == OP_XST)) begin
            xadr_r <= xadr;
        end
    end

    // Extended area store; no reset, contents undefined until written
    always_ff @(posedge ref_clk) begin
        if (exec && cw.op == OP_XST) begin
            xmem[xi] <= src_r[7:0];
            if (cw.word) xmem[xi1] <= src_r[15:8];
        end
    end

    // Remembers an idle previous cycle for the ready delay after a walk
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            was_idle_r <= 1'b1;
        end else begin
            was_idle_r <= (state_r == ST_IDLE);
        end
    end

    // Save walks registers 7 down to 0, restore 0 up to 7, one per cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            idx_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (exec && cw.op == OP_SAVE) begin
                        state_r <= ST_SAVE;
                        idx_r   <= 3'h7;
                    end else if (exec && cw.op == OP_REST) begin
                        state_r <= ST_REST;
                        idx_r   <= 3'h0;
                    end
                end
                ST_SAVE: begin
                    idx_r <= idx_r - 3'h1;
                    if (idx_r == 3'h0) state_r <= ST_IDLE;
                end
                ST_REST: begin
                    idx_r <= idx_r + 3'h1;
                    if (idx_r == 3'h7) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= '0;
        end else if (state_r == ST_SAVE && mask_r[idx_r]) begin
            sp_r <= sp_r - SP_W'(1);
        end else if (state_r == ST_REST && mask_r[idx_r]) begin
            sp_r <= sp_r + SP_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (state_r == ST_SAVE && mask_r[idx_r]) begin
            stk[sp_r - SP_W'(1)] <= gpr[idx_r];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) gpr[i] <= '0;
        end else if (state_r == ST_REST) begin
            if (mask_r[idx_r]) gpr[idx_r] <= stk[sp_r];
        end else if (exec && nib_op && n_tgt != NB_MEM) begin
            if (n_tgt[0]) begin
                gpr[{2'h0, n_tgt[1]}][15:8] <= n_val;
            end else begin
                gpr[{2'h0, n_tgt[1]}][7:0] <= n_val;
            end
        end else if (wr && gpr_hit(paddr)) begin
            gpr[paddr[4:2]] <= pwdata[15:0];
        end
    end

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        if (gpr_hit(paddr)) begin
            rd_mux[15:0] = gpr[paddr[4:2]];
        end else begin
            unique case (paddr)
                OFS_CTRL:   rd_mux = ctrl_r;
                OFS_SRC:    rd_mux[15:0] = src_r;
                OFS_DST:    rd_mux[15:0] = dst_r;
                OFS_FLAGS:  rd_mux[3:0] = flag_r;
                OFS_IMM:    rd_mux[15:0] = imm_r;
                OFS_BITCNT: rd_mux = {3'h0, 13'(bitcnt_r >> BYTE_SHIFT), bitcnt_r};
                OFS_EA:     rd_mux[19:0] = ea_r;
                OFS_EXTADR: rd_mux[19:0] = xadr_r;
                OFS_STATUS: rd_mux = {20'h0, 4'(sp_r), 7'h0, state_r != ST_IDLE};
                OFS_MASK:   rd_mux[7:0] = mask_r;
                default:    mapped = 1'b0;
            endcase
        end
    end

    // Captured every selected cycle so the access phase shows it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel) begin
            prdata <= rd_mux;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_save_start;
        exec && cw.op == OP_SAVE;
    endsequence
    sequence s_walk;
        (state_r != ST_IDLE) [*8] ##1 (state_r == ST_IDLE && !pready) ##1 pready;
    endsequence

    AST_SAVE_WALK: assert property (s_save_start |=> s_walk)
        else $error("register set save did not take eight cycles");
    AST_CSNZ_HOLD: assert property (exec && cw.op == OP_CSNZ && flag_r.z |=> $stable({dst_r, flag_r}))
        else $error("untaken store changed state");
    AST_CSNZ_WR: assert property (exec && cw.op == OP_CSNZ && !flag_r.z |=> dst_r[7:0] == $past(imm_r[7:0]))
        else $error("store if nonzero missed");
    AST_CSZ_WR: assert property (exec && cw.op == OP_CSZ && flag_r.z |=> dst_r[7:0] == $past(imm_r[7:0]))
        else $error("store if zero missed");
    AST_CSSEL: assert property (exec && cw.op == OP_CSSEL && !flag_r.z |=> dst_r[7:0] == $past(imm_r[15:8]))
        else $error("select store took wrong immediate");
    AST_BOR_C: assert property (exec && cw.op == OP_BORC |=> flag_r.c == ($past(sbit) | $past(flag_r.c)))
        else $error("bit or into carry wrong");
    AST_TCLR: assert property (exec && cw.op == OP_TCLR |=> flag_r.c == $past(dbit) && !dst_r[bsel])
        else $error("test then clear wrong");
    AST_BMOV_FLG: assert property (exec && cw.op == OP_BMOV && !cw.fdir |=> $stable(flag_r))
        else $error("bit move altered flags");
    AST_BMOV_VAL: assert property (exec && cw.op == OP_BMOV && !cw.fdir |=> dst_r[bsel] == $past(cond_ok))
        else $error("bit move wrote wrong value");
    AST_SWAP: assert property (exec && cw.op == OP_SWAP && cw.word |=> src_r == $past(dst_r))
        else $error("swap did not exchange");
    AST_MVADR: assert property (exec && cw.op == OP_MVADR |=> dst_r == $past(ea_r[15:0]))
        else $error("address move wrong");
endmodule

// file: core/tbou_pkg.sv
/*
 * Shared constants and types of the transfer and bit operation unit.
 * Assumes an APB master on the same clock as the unit.
 */
package tbou_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SRC    = 8'h04;
    localparam logic [7:0] OFS_DST    = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0c;
    localparam logic [7:0] OFS_IMM    = 8'h10;
    localparam logic [7:0] OFS_BITCNT = 8'h14;
    localparam logic [7:0] OFS_EA     = 8'h18;
    localparam logic [7:0] OFS_EXTADR = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_MASK   = 8'h24;
    localparam logic [2:0] GPR_PAGE   = 3'h2;
    localparam logic [3:0] RST_FLAGS  = 4'h0;
    localparam int unsigned BYTE_SHIFT = 3;
    // Operation codes
    localparam logic [4:0] OP_MOV   = 5'h00;
    localparam logic [4:0] OP_MVADR = 5'h01;
    localparam logic [4:0] OP_NHH   = 5'h02;
    localparam logic [4:0] OP_NHL   = 5'h03;
    localparam logic [4:0] OP_NLH   = 5'h04;
    localparam logic [4:0] OP_NLL   = 5'h05;
    localparam logic [4:0] OP_SAVE  = 5'h06;
    localparam logic [4:0] OP_REST  = 5'h07;
    localparam logic [4:0] OP_XLD   = 5'h08;
    localparam logic [4:0] OP_XST   = 5'h09;
    localparam logic [4:0] OP_CSNZ  = 5'h0a;
    localparam logic [4:0] OP_CSZ   = 5'h0b;
    localparam logic [4:0] OP_CSSEL = 5'h0c;
    localparam logic [4:0] OP_SWAP  = 5'h0d;
    localparam logic [4:0] OP_BMOV  = 5'h0e;
    localparam logic [4:0] OP_BAND  = 5'h0f;
    localparam logic [4:0] OP_BORC  = 5'h10;
    localparam logic [4:0] OP_BXORC = 5'h11;
    localparam logic [4:0] OP_NBAND = 5'h12;
    localparam logic [4:0] OP_NBOR  = 5'h13;
    localparam logic [4:0] OP_NBXOR = 5'h14;
    localparam logic [4:0] OP_BZERO = 5'h15;
    localparam logic [4:0] OP_BSETO = 5'h16;
    localparam logic [4:0] OP_BINV  = 5'h17;
    localparam logic [4:0] OP_BTEST = 5'h18;
    localparam logic [4:0] OP_NBTST = 5'h19;
    localparam logic [4:0] OP_TCLR  = 5'h1a;
    localparam logic [4:0] OP_TSET  = 5'h1b;
    // Extended area addressing modes
    localparam logic [1:0] XM_ABS20 = 2'h0;
    localparam logic [1:0] XM_PAIR  = 2'h1;
    localparam logic [1:0] XM_DSP20 = 2'h2;
    // Nibble partner byte select; 0 is the low byte of register zero
    localparam logic [2:0] NB_GPR0L = 3'h0;
    localparam logic [2:0] NB_MEM   = 3'h4;
    localparam logic [2:0] IDX_AR0  = 3'h4;
    localparam logic [2:0] IDX_AR1  = 3'h5;

    typedef struct packed {
        logic o;
        logic s;
        logic z;
        logic c;
    } tbou_flags_t;

    typedef struct packed {
        logic [14:0] rsv;
        logic [1:0]  xmode;
        logic [3:0]  cond;
        logic [2:0]  nsel;
        logic        ndir;
        logic        fdir;
        logic        word;
        logic [4:0]  op;
    } tbou_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAVE = 3'b010,
        ST_REST = 3'b100
    } tbou_state_t;
endpackage

// file: sim/tbou_bench.sv
/*
 * Self-checking bench for the transfer and bit operation unit, driven over APB.
 * Assumes the register map and opcode set of tbou_pkg and zero-wait answers when idle.
 */
`timescale 1ns/10ps
module tbou_bench;
    import tbou_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    tbou_flags_t flags_out;
    logic [31:0] rv;
    logic        er;
    int          mismatches  = 0;
    int          checks_done = 0;

    always #2 ref_clk = ~ref_clk;

    tbou_core #(.STK_DEPTH(16), .EXT_DEPTH(16)) tbou_core_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags_out(flags_out)
    );

    task report_and_stop();
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one idle cycle so no signal is driven twice at once
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        rv = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("[FAIL] t=%0t pready=%h exp=%h", $time, pready, 1'b1);
            report_and_stop();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
        checks_done++;
        if ((got & m) !== (exp & m)) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
        xfer(1'b0, a, 32'h0);
        chk(rv, exp, m);
    endtask

    task op(input logic [31:0] fl, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
        wr(OFS_FLAGS, fl);
        wr(OFS_SRC, s);
        wr(OFS_DST, d);
        wr(OFS_CTRL, c);
    endtask

    // dirs is {ndir, fdir, word}
    function automatic logic [31:0] mk(input logic [4:0] o, input logic [2:0] dirs = 3'h1,
                                       input logic [3:0] cnd = 4'h0, input logic [2:0] ns = 3'h0,
                                       input logic [1:0] xm = 2'h0);
        tbou_ctrl_t c;
        c = '0;
        c.op = o;
        {c.ndir, c.fdir, c.word} = dirs;
        c.cond = cnd;
        c.nsel = ns;
        c.xmode = xm;
        return c;
    endfunction

    // f is {o, s, z, c}
    function automatic logic cnd_ok(input logic [3:0] k, input logic [3:0] f);
        logic o, s, z, c;
        {o, s, z, c} = f;
        case (k)
            4'h0: return c;
            4'h1: return !c;
            4'h2: return z;
            4'h3: return !z;
            4'h4: return c & z;
            4'h5: return !(c & z);
            4'h6: return !s;
            4'h7: return s;
            4'h8: return !(s ^ o);
            4'h9: return (s ^ o) | z;
            4'ha: return !((s ^ o) | z);
            4'hb: return s ^ o;
            4'hc: return o;
            4'hd: return !o;
            default: return 1'b0;
        endcase
    endfunction

    logic [15:0] nib [4] = '{16'h3cac, 16'h3c3a, 16'h3c5c, 16'h3c35};
    logic [31:0] xa  [3] = '{32'h3, 32'h10006, 32'h9};

    initial begin
        logic e, b, r, t;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdchk(OFS_FLAGS, 32'h0);
        chk({31'h0, er}, 32'h0);
        chk({28'h0, flags_out}, 32'h0);
        rdchk(OFS_STATUS, 32'h0);
        rdchk(8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        op(32'ha, 32'ha1b2, 32'h5555, mk(OP_MOV));
        rdchk(OFS_DST, 32'ha1b2);
        rdchk(OFS_FLAGS, 32'ha);
        op(32'h0, 32'h00c3, 32'h5555, mk(OP_MOV, 3'h0));
        rdchk(OFS_DST, 32'h55c3);
        wr(8'h40, 32'h00a5);
        for (int i = 0; i < 4; i++) begin
            wr(8'h44, 32'h3c3c);
            wr(OFS_CTRL, mk(OP_NHH + 5'(i), 3'h1, 4'h0, 3'h2));
            rdchk(8'h44, {16'h0, nib[i]});
            rdchk(8'h40, 32'h00a5);
        end
        wr(OFS_DST, 32'h00e7);
        wr(OFS_CTRL, mk(OP_NLL, 3'b101, 4'h0, NB_MEM));
        rdchk(8'h40, 32'h00a7);
        wr(OFS_CTRL, mk(OP_NHL, 3'h1, 4'h0, NB_MEM));
        rdchk(OFS_DST, 32'h00ea);
        rdchk(8'h40, 32'h00a7);
        wr(OFS_EA, 32'h12345);
        wr(OFS_CTRL, mk(OP_MVADR));
        rdchk(OFS_DST, 32'h2345);
        wr(8'h40, 32'h1111);
        wr(8'h44, 32'h2222);
        wr(8'h48, 32'h3333);
        wr(OFS_MASK, 32'h3);
        wr(OFS_CTRL, mk(OP_SAVE));
        rdchk(OFS_STATUS, 32'h0e00);
        wr(8'h40, 32'h0);
        wr(8'h44, 32'h0);
        wr(8'h48, 32'h7777);
        wr(OFS_CTRL, mk(OP_REST));
        rdchk(8'h40, 32'h1111);
        rdchk(8'h44, 32'h2222);
        rdchk(8'h48, 32'h7777);
        rdchk(OFS_STATUS, 32'h0);
        wr(8'h50, 32'h6);
        wr(8'h54, 32'h1);
        wr(OFS_EA, 32'h3);
        for (int m = 0; m < 3; m++) begin
            wr(OFS_SRC, 32'hbe00 + m);
            wr(OFS_CTRL, mk(OP_XST, 3'h1, 4'h0, 3'h0, 2'(m)));
            rdchk(OFS_EXTADR, xa[m]);
        end
        for (int m = 0; m < 3; m++) begin
            wr(OFS_CTRL, mk(OP_XLD, 3'h1, 4'h0, 3'h0, 2'(m)));
            rdchk(OFS_DST, 32'hbe00 + m);
        end
        wr(OFS_IMM, 32'h9a3c);
        for (int z = 0; z < 2; z++) begin
            for (int k = 0; k < 3; k++) begin
                op(32'(z << 1), 32'h0, 32'h5555, mk(OP_CSNZ + 5'(k), 3'h0));
                t = (k == 0) ? (z == 0) : ((k == 1) ? (z == 1) : 1'b1);
                if (t) begin
                    rdchk(OFS_DST, (k == 2 && z == 0) ? 32'h9a : 32'h3c, 32'hff);
                end else begin
                    rdchk(OFS_DST, 32'h5555);
                end
                rdchk(OFS_FLAGS, 32'(z << 1));
            end
        end
        op(32'h0, 32'h1111, 32'h2222, mk(OP_SWAP));
        rdchk(OFS_SRC, 32'h2222);
        rdchk(OFS_DST, 32'h1111);
        wr(OFS_BITCNT, 32'h5);
        for (int f = 0; f < 16; f++) begin
            for (int k = 0; k < 14; k++) begin
                e = cnd_ok(4'(k), 4'(f));
                op(32'(f), 32'h0, e ? 32'hffdf : 32'h0020, mk(OP_BMOV, 3'h1, 4'(k)));
                rdchk(OFS_DST, e ? 32'hffff : 32'h0);
                rdchk(OFS_FLAGS, 32'(f));
            end
        end
        for (int i = 0; i < 2; i++) begin
            op(32'(i), 32'h0, 32'h0, mk(OP_BMOV, 3'b011, 4'(3 - i)));
            rdchk(OFS_FLAGS, 32'(1 - i));
            chk({28'h0, flags_out}, 32'(1 - i));
            rdchk(OFS_DST, 32'h0);
        end
        for (int k = 0; k < 6; k++) begin
            for (int s = 0; s < 4; s++) begin
                b = (k >= 3) ? !s[1] : s[1];
                r = (k % 3 == 0) ? (b & s[0]) : ((k % 3 == 1) ? (b | s[0]) : (b ^ s[0]));
                op(32'hc | s[0], s[1] ? 32'h0020 : 32'hffdf, 32'h0, mk(OP_BAND + 5'(k)));
                rdchk(OFS_FLAGS, {28'h0, 3'b110, r});
            end
        end
        for (int k = 0; k < 3; k++) begin
            for (int v = 0; v < 2; v++) begin
                op(32'h0, 32'h0, v ? 32'h0f20 : 32'h0f00, mk(OP_BZERO + 5'(k)));
                t = (k == 0) ? 1'b0 : ((k == 1) ? 1'b1 : !v);
                rdchk(OFS_DST, t ? 32'h0f20 : 32'h0f00);
            end
        end
        for (int k = 0; k < 4; k++) begin
            for (int v = 0; v < 2; v++) begin
                op(32'hc, v ? 32'h20 : 32'h0, v ? 32'h20 : 32'h0, mk(OP_BTEST + 5'(k)));
                t = (k == 1) ? !v : v;
                rdchk(OFS_FLAGS, {28'h0, 2'b11, !v[0], t});
                rdchk(OFS_DST, (k == 2) ? 32'h0 : ((k == 3) ? 32'h20 : (v ? 32'h20 : 32'h0)));
            end
        end
        wr(OFS_BITCNT, 32'h1234);
        rdchk(OFS_BITCNT, 32'h02461234);
        report_and_stop();
    end
endmodule
